// File: chan_adapt_pkg.sv
// constants shared by the channel adapter design
// Operation
// - sink lacks channel: flag nonzero source channel
// - source lacks channel: sink channel tied zero
// - smaller source range: pass, upper bits zero
// - larger source range: pass low bits
// - flag source channel above sink maximum
// - out-of-range beats never reach sink valid
// - channel width zero to eight bits
// - maximum channel zero through 255
// - error width zero to 31 bits
// - empty count qualifies end-of-packet beat only
// - error bit meanings must match both sides
package chan_adapt_pkg;
    // ==========================================================
    // parameter limits and default fifo depth
    localparam int CHAN_W_MAX   = 8;
    localparam int MAX_CHAN_TOP = 255;
    localparam int ERR_W_MAX    = 31;
    localparam int FIFO_DEPTH   = 16;
    // ==========================================================
    // reset values
    localparam logic CHAN_ZERO  = 1'h0;
endpackage : chan_adapt_pkg

// File: chan_adapt.sv
// streaming channel adapter with output fifo
`timescale 1ns/100ps

// ==========================================================
// fifo: registered storage with valid/ready on both sides
module chan_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_s;
    fifo_s             st;
    fifo_s             next_st;
    logic [WIDTH-1:0]  mem [DEPTH];
    logic              push;
    logic              pop;

    // handshakes; full and empty are exact from the count
    assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[st.rd];

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[st.wr] <= in_data;
        end
    end
endmodule : chan_fifo

// ==========================================================
// adapter top
module chan_adapt
    import chan_adapt_pkg::*;
#(
    parameter int DATA_W     = 32,
    parameter int EMPTY_W    = 2,
    parameter int ERR_W      = 1,
    parameter int IN_CHAN_W  = 4,
    parameter int IN_MAX     = 15,
    parameter int OUT_CHAN_W = 2,
    parameter int OUT_MAX    = 3,
    parameter int DEPTH      = FIFO_DEPTH
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic [DATA_W-1:0]           in_data,
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire logic                        in_sop,
    input  wire logic                        in_eop,
    input  wire logic [EMPTY_W-1:0]          in_empty,
    input  wire logic [ERR_W-1:0]            in_error,
    input  wire logic [CHAN_W_MAX-1:0]       in_channel,
    output logic      [DATA_W-1:0]           out_data,
    output logic                             out_valid,
    input  wire logic                        out_ready,
    output logic                             out_sop,
    output logic                             out_eop,
    output logic      [EMPTY_W-1:0]          out_empty,
    output logic      [ERR_W-1:0]            out_error,
    output logic      [CHAN_W_MAX-1:0]       out_channel,
    output logic                             chan_error
);
    // channel widths and maximums held to their legal ranges; out-of-range values saturate
    // rather than stop elaboration, so a bad setting degrades instead of failing
    localparam int IN_CW  = (IN_CHAN_W < 0) ? 0 : ((IN_CHAN_W > CHAN_W_MAX) ? CHAN_W_MAX : IN_CHAN_W);
    localparam int OUT_CW = (OUT_CHAN_W < 0) ? 0 : ((OUT_CHAN_W > CHAN_W_MAX) ? CHAN_W_MAX : OUT_CHAN_W);
    localparam int IN_MX  = (IN_MAX < 0) ? 0 : ((IN_MAX > MAX_CHAN_TOP) ? MAX_CHAN_TOP : IN_MAX);
    localparam int OUT_MX = (OUT_MAX < 0) ? 0 : ((OUT_MAX > MAX_CHAN_TOP) ? MAX_CHAN_TOP : OUT_MAX);
    // error field: ERR_W from 1 to ERR_W_MAX; zero width is one bit tied low by the integrator

    localparam int PW = DATA_W + EMPTY_W + ERR_W + 2 + CHAN_W_MAX;

    function automatic logic [CHAN_W_MAX-1:0] keep_low(input logic [CHAN_W_MAX-1:0] v, input int w);
        logic [CHAN_W_MAX-1:0] m;
        m = '0;
        for (int i = 0; i < CHAN_W_MAX; i++) begin
            m[i] = (i < w);
        end
        return v & m;
    endfunction : keep_low

    typedef struct packed {
        logic err;
    } adapt_s;
    adapt_s                 st;
    adapt_s                 next_st;
    logic [CHAN_W_MAX-1:0]  src_chan;
    logic [CHAN_W_MAX-1:0]  snk_chan;
    logic                   bad_beat;
    logic                   f_in_ready;
    logic                   f_valid;
    logic [PW-1:0]          f_out;

    // channel mapping and range check per configuration
    always_comb begin
        src_chan = keep_low(in_channel, IN_CW);
        snk_chan = '0;
        bad_beat = 1'b0;
        if (IN_CW == 0) begin
            snk_chan = '0;
        end else if (OUT_CW == 0) begin
            bad_beat = (src_chan != '0);
        end else begin
            // widening pads zeros, narrowing drops upper bits
            snk_chan = keep_low(src_chan, OUT_CW);
            if (IN_MX > OUT_MX) begin
                bad_beat = (32'(src_chan) > OUT_MX);
            end
        end
    end

    // dropped beats are consumed only while the fifo has room; ready follows the fifo for every beat
    assign in_ready = f_in_ready;

    // error indication: registered flag for each rejected beat taken
    always_comb begin
        next_st.err = in_valid && f_in_ready && bad_beat;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign chan_error = st.err;

    // out-of-range beats are never written, so the sink never sees them
    chan_fifo #(
        .WIDTH (PW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_data   ({in_data, in_empty, in_error, in_sop, in_eop, snk_chan}),
        .in_valid  (in_valid && !bad_beat),
        .in_ready  (f_in_ready),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (out_ready)
    );

    // fields unpacked unchanged from fifo storage
    assign out_valid = f_valid;
    assign {out_data, out_empty, out_error, out_sop, out_eop, out_channel} = f_out;
endmodule : chan_adapt

// File: chan_adapt_properties.sv
// port-level checks for the channel adapter
`timescale 1ns/100ps
module chan_adapt_properties #(
    parameter int OUT_MAX = 3
) (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       in_valid,
    input wire logic       in_ready,
    input wire logic [7:0] in_channel,
    input wire logic       out_valid,
    input wire logic       out_ready,
    input wire logic [7:0] out_channel,
    input wire logic       chan_error
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // taken beats, split by whether the sink can hold the channel
    sequence bad;
        in_valid && in_ready && in_channel > OUT_MAX;
    endsequence
    sequence ok;
        in_valid && in_ready && in_channel <= OUT_MAX;
    endsequence
    a_bad_flag: assert property (bad |=> chan_error) else $error("flag missing");
    a_ok_quiet: assert property (ok |=> !chan_error) else $error("false flag");
    a_bad_dropped: assert property (bad ##0 !out_valid |=> !out_valid) else $error("bad beat out");
    a_ok_lands: assert property (ok |=> out_valid) else $error("beat lost");
    a_out_range: assert property (out_valid |-> out_channel <= OUT_MAX) else $error("channel range");
    a_upper_zero: assert property (out_valid |-> out_channel[7:2] == 6'h00) else $error("upper bits");
    a_head_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_channel))
        else $error("head moved");
    a_empty_open: assert property (!out_valid |-> in_ready) else $error("ready low");
endmodule : chan_adapt_properties

// File: sink_model.sv
// sink partner that can stall the adapter
`timescale 1ns/100ps
module sink_model (
    input  wire logic stall,
    output logic      out_ready
);
    // a slow sink is just ready held low
    assign out_ready = !stall;
endmodule : sink_model

// File: testbench.sv
// self-checking bench for the channel adapter
`timescale 1ns/100ps
module testbench;
    logic        ref_clk, rst_b, in_valid, in_ready, in_sop, in_eop, in_error, stall;
    logic        out_valid, out_ready, out_sop, out_eop, out_error, chan_error;
    logic [1:0]  in_empty, out_empty;
    logic [7:0]  in_channel, out_channel;
    logic [31:0] in_data, out_data;
    logic [39:0] exp_q[$];
    int          mismatches, checks_done, flags, cycles;
    chan_adapt chan_adapt_i (.ref_clk(ref_clk), .rst_b(rst_b), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .in_sop(in_sop), .in_eop(in_eop), .in_empty(in_empty), .in_error(in_error),
        .in_channel(in_channel), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_sop(out_sop), .out_eop(out_eop), .out_empty(out_empty), .out_error(out_error),
        .out_channel(out_channel), .chan_error(chan_error));
    sink_model sink_model_i (.stall(stall), .out_ready(out_ready));
    // ==========================================================
    // compare, verdict and beat driver
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // holds the beat until the edge that takes it; valid left up for back to back
    task automatic put(input logic [3:0] ch, input logic [31:0] d);
        logic r;
        in_valid <= 1'h1;
        in_channel <= {4'h0, ch};
        in_data <= d;
        {in_sop, in_empty, in_error, in_eop} <= d[4:0];
        if (ch <= 4'h3) exp_q.push_back({4'h0, ch, d});
        do begin
            @(negedge ref_clk) r = in_ready;
            @(posedge ref_clk);
        end while (!r);
    endtask : put
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    // score every beat the sink takes; count flags; cut a hang short
    always @(posedge ref_clk) begin
        if (rst_b && out_valid && out_ready) begin
            chk("channel", exp_q[0][39:32], out_channel);
            chk("data", exp_q[0][31:0], out_data);
            chk("side", exp_q[0][4:0], {out_sop, out_empty, out_error, out_eop});
            void'(exp_q.pop_front());
        end
        flags <= flags + chan_error;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {rst_b, in_valid, in_sop, in_eop, in_error, stall} = 6'h00;
        {in_empty, in_channel, in_data} = 42'h0;
        {mismatches, checks_done, flags, cycles} = 128'h0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'h1;
        // every source channel; only 0 to 3 fit the sink
        for (int i = 0; i < 16; i++) put(i[3:0], 32'hA5000000 + i);
        in_valid <= 1'h0;
        repeat (4) @(posedge ref_clk);
        chk("flags", 32'd12, flags);
        $display("channel sweep done");
        // stalled sink: fill all 16 entries, check ready low, then drain
        stall <= 1'h1;
        for (int i = 0; i < 16; i++) put({2'h0, i[1:0]}, 32'h5A000000 + i);
        in_valid <= 1'h0;
        @(negedge ref_clk) chk("ready", 32'h0, in_ready);
        @(posedge ref_clk) stall <= 1'h0;
        repeat (20) @(posedge ref_clk);
        chk("drained", 32'h0, 32'(exp_q.size()));
        chk("out_valid", 32'h0, {31'h0, out_valid});
        $display("fill and drain done");
        close_out();
    end
endmodule : testbench
bind chan_adapt chan_adapt_properties #(.OUT_MAX(3)) chan_adapt_properties_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .in_valid(in_valid), .in_ready(in_ready), .in_channel(in_channel), .out_valid(out_valid),
    .out_ready(out_ready), .out_channel(out_channel), .chan_error(chan_error));
